// file: core/mrx_pkg.sv
// package: constants, register map and carrier types of the mii receive frame checker
package mrx_pkg;

  // ==========================================================================
  // geometry
  localparam int unsigned NPORT      = 2;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned NIB_W      = 4;
  localparam int unsigned PCNT_W     = 5;
  localparam int unsigned DCNT_W     = 17;
  localparam int unsigned FLIM_W     = 16;
  localparam int unsigned ERR_W      = 4;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_FRM_LIMITS0  = 8'h40;
  localparam logic [7:0] OFF_FRM_LIMITS1  = 8'h44;
  localparam logic [7:0] OFF_PRE_LIMITS0  = 8'h48;
  localparam logic [7:0] OFF_PRE_LIMITS1  = 8'h4C;
  localparam logic [7:0] OFF_ERR_STATUS0  = 8'h50;
  localparam logic [7:0] OFF_ERR_STATUS1  = 8'h54;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h58;
  localparam logic [7:0] OFF_IRQ_CLEAR    = 8'h5C;
  localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h60;

  // ==========================================================================
  // field positions
  localparam int unsigned PRE_LO_LSB      = 0;
  localparam int unsigned PRE_UP_LSB      = 4;
  localparam int unsigned FRM_LO_LSB      = 0;
  localparam int unsigned FRM_UP_LSB      = 16;
  localparam int unsigned ERR_PRE_SHORT   = 0;
  localparam int unsigned ERR_PRE_LONG    = 1;
  localparam int unsigned ERR_FRM_SHORT   = 2;
  localparam int unsigned ERR_FRM_LONG    = 3;

  // ==========================================================================
  // reset values
  localparam logic [7:0]  PRE_LIMITS_RST  = 8'hE1;
  localparam logic [31:0] FRM_LIMITS_RST  = 32'h05F1003F;
  localparam logic [7:0]  IRQ_ENABLE_RST  = 8'h00;

  // ==========================================================================
  // preamble, delimiter and frame limit decoding
  localparam logic [7:0]        SFD_BYTE        = 8'h5D;
  localparam logic [PCNT_W-1:0] SFD_NIBBLES     = 5'h02;
  localparam logic [PCNT_W-1:0] TRUNC_NIBBLES   = 5'h10;
  localparam logic [3:0]        PRE_UP_OFF      = 4'h0;
  localparam logic [3:0]        PRE_UP_RSVD     = 4'h1;
  localparam logic [PCNT_W-1:0] PRE_UP_BIAS     = 5'h02;
  localparam logic [DCNT_W-1:0] FRM_LIMIT_BIAS  = 17'h00001;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PRE,
    ST_DATA,
    ST_DROP
  } mrx_state_t;

  // one nibble of the forwarded receive stream
  typedef struct packed {
    logic            vld;
    logic [NIB_W-1:0] nib;
    logic            eof;
    logic            odd;
    logic            trunc;
  } mrx_strm_t;

endpackage

// file: core/mrx_sync.sv
// two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
module mrx_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // ==========================================================================
  // stages
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // mrx_sync

// file: core/mrx_top.sv
// mii receive preamble and frame length checker with register file
//
// Behaviour
// - count nibbles until byte 0x5D seen
// - preamble over upper limit raises error
// - no delimiter by nibble 16: error, truncate
// - upper limit 0 off, 1 reserved, N+2
// - sixteenth nibble still forwarded as data
// - preamble under lower limit raises error
// - lower limit 0 off, N preamble nibbles
// - preamble nibble values not checked
// - status bit 3: frame too long
// - status bit 2: frame too short
// - status bit 1: preamble too long
// - status bit 0: preamble too short
// - bytes after delimiter over upper limit
// - bytes after delimiter under lower limit
// - frame limit N means N+1 bytes
`timescale 1ns/1ns
module mrx_top (
  input  wire logic                                    core_clk,
  input  wire logic                                    rst,
  input  wire logic [mrx_pkg::ADDR_W-1:0]              reg_addr,
  input  wire logic [mrx_pkg::DATA_W-1:0]              reg_wdata,
  input  wire logic                                    reg_wr,
  input  wire logic                                    reg_rd,
  output logic      [mrx_pkg::DATA_W-1:0]              reg_rdata,
  input  wire logic [mrx_pkg::NPORT-1:0]               mii_rx_clk,
  input  wire logic [mrx_pkg::NPORT-1:0]               mii_rx_dv,
  input  wire logic [mrx_pkg::NPORT-1:0][3:0]          mii_rxd,
  output mrx_pkg::mrx_strm_t [mrx_pkg::NPORT-1:0]      rx_strm,
  output logic                                         irq
);

  localparam int unsigned NP  = mrx_pkg::NPORT;
  localparam int unsigned NIB = mrx_pkg::NIB_W;
  localparam int unsigned IW  = NP * mrx_pkg::ERR_W;

  // ==========================================================================
  // register file state
  // limits are read/write per port; error status only ever gains bits
  logic [7:0]                    plim_q [NP];
  logic [7:0]                    plim_d [NP];
  logic [31:0]                   flim_q [NP];
  logic [31:0]                   flim_d [NP];
  logic [mrx_pkg::ERR_W-1:0]     err_q  [NP];
  logic [mrx_pkg::ERR_W-1:0]     err_d  [NP];
  logic [IW-1:0]                 ist_q;
  logic [IW-1:0]                 ist_d;
  logic [IW-1:0]                 ien_q;
  logic [IW-1:0]                 ien_d;
  logic                          irq_q;
  logic                          irq_d;
  logic [mrx_pkg::DATA_W-1:0]    rdata_q;
  logic [mrx_pkg::DATA_W-1:0]    rdata_d;
  logic [NP-1:0][mrx_pkg::ERR_W-1:0] ev;
  logic [IW-1:0]                 iclr;

  // ==========================================================================
  // per-port receive checker
  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      logic [NIB+1:0]                 sync_q;
      logic                           clk_s;
      logic                           dv_s;
      logic [NIB-1:0]                 nib_s;
      logic                           clk_d1_q;
      logic                           stb;
      mrx_pkg::mrx_state_t            st_q;
      mrx_pkg::mrx_state_t            st_d;
      logic [mrx_pkg::PCNT_W-1:0]     pcnt_q;
      logic [mrx_pkg::PCNT_W-1:0]     pcnt_d;
      logic [mrx_pkg::PCNT_W-1:0]     pcnt_n;
      logic [mrx_pkg::DCNT_W-1:0]     dcnt_q;
      logic [mrx_pkg::DCNT_W-1:0]     dcnt_d;
      logic [mrx_pkg::DCNT_W-1:0]     nbytes;
      logic [NIB-1:0]                 prev_q;
      logic [NIB-1:0]                 prev_d;
      mrx_pkg::mrx_strm_t             strm_q;
      mrx_pkg::mrx_strm_t             strm_d;
      logic [mrx_pkg::ERR_W-1:0]      ev_p;
      logic [3:0]                     pre_up;
      logic [3:0]                     pre_lo;
      logic [mrx_pkg::FLIM_W-1:0]     frm_up;
      logic [mrx_pkg::FLIM_W-1:0]     frm_lo;
      logic                           up_en;

      mrx_sync #(
        .W (NIB + 2)
      ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        ({mii_rx_clk[p], mii_rx_dv[p], mii_rxd[p]}),
        .q        (sync_q)
      );

      assign clk_s = sync_q[NIB+1];
      assign dv_s  = sync_q[NIB];
      assign nib_s = sync_q[NIB-1:0];
      // sample on the falling link edge: mid-window, away from the data change
      assign stb   = clk_d1_q & ~clk_s;

      assign pre_up = plim_q[p][mrx_pkg::PRE_UP_LSB +: 4];
      assign pre_lo = plim_q[p][mrx_pkg::PRE_LO_LSB +: 4];
      assign frm_up = flim_q[p][mrx_pkg::FRM_UP_LSB +: mrx_pkg::FLIM_W];
      assign frm_lo = flim_q[p][mrx_pkg::FRM_LO_LSB +: mrx_pkg::FLIM_W];
      // reserved upper-limit code is treated as disabled
      assign up_en  = (pre_up != mrx_pkg::PRE_UP_OFF) &&
                      (pre_up != mrx_pkg::PRE_UP_RSVD);
      assign pcnt_n = pcnt_q + 5'h01;
      // a trailing odd nibble is not counted as a byte
      assign nbytes = {1'b0, dcnt_q[mrx_pkg::DCNT_W-1:1]};

      // ======================================================================
      // frame state machine: idle, preamble hunt, payload count, drop after cut
      always_comb begin
        st_d         = st_q;
        pcnt_d       = pcnt_q;
        dcnt_d       = dcnt_q;
        prev_d       = prev_q;
        ev_p         = '0;
        strm_d       = '0;
        strm_d.nib   = nib_s;
        if (stb) begin
          case (st_q)
            mrx_pkg::ST_IDLE: begin
              // the first nibble of a frame already counts as preamble
              if (dv_s) begin
                pcnt_d     = 5'h01;
                prev_d     = nib_s;
                strm_d.vld = 1'b1;
                st_d       = mrx_pkg::ST_PRE;
              end
            end
            mrx_pkg::ST_PRE: begin
              if (!dv_s) begin
                // frame ended before any delimiter: mark the end, judge nothing
                strm_d.eof = 1'b1;
                st_d       = mrx_pkg::ST_IDLE;
              end else begin
                pcnt_d     = pcnt_n;
                prev_d     = nib_s;
                strm_d.vld = 1'b1;
                // delimiter test first: a delimiter on the limit nibble is on time
                if ({prev_q, nib_s} == mrx_pkg::SFD_BYTE) begin
                  dcnt_d = '0;
                  st_d   = mrx_pkg::ST_DATA;
                  if ((pre_lo != 4'h0) &&
                      ((pcnt_n - mrx_pkg::SFD_NIBBLES) < {1'b0, pre_lo})) begin
                    ev_p[mrx_pkg::ERR_PRE_SHORT] = 1'b1;
                  end
                end else begin
                  if (up_en && (pcnt_n == ({1'b0, pre_up} + mrx_pkg::PRE_UP_BIAS))) begin
                    ev_p[mrx_pkg::ERR_PRE_LONG] = 1'b1;
                  end
                  if (pcnt_n == mrx_pkg::TRUNC_NIBBLES) begin
                    // this nibble still goes out, the rest of the frame does not
                    ev_p[mrx_pkg::ERR_PRE_LONG] = 1'b1;
                    strm_d.trunc = 1'b1;
                    st_d         = mrx_pkg::ST_DROP;
                  end
                end
              end
            end
            mrx_pkg::ST_DATA: begin
              if (dv_s) begin
                // saturate rather than wrap so a huge frame still reads as too long
                if (dcnt_q != '1) begin
                  dcnt_d = dcnt_q + 17'h00001;
                end
                strm_d.vld = 1'b1;
              end else begin
                strm_d.eof = 1'b1;
                strm_d.odd = dcnt_q[0];
                if (nbytes > ({1'b0, frm_up} + mrx_pkg::FRM_LIMIT_BIAS)) begin
                  ev_p[mrx_pkg::ERR_FRM_LONG] = 1'b1;
                end
                if (nbytes < ({1'b0, frm_lo} + mrx_pkg::FRM_LIMIT_BIAS)) begin
                  ev_p[mrx_pkg::ERR_FRM_SHORT] = 1'b1;
                end
                st_d = mrx_pkg::ST_IDLE;
              end
            end
            mrx_pkg::ST_DROP: begin
              // truncated frame ends silently: no end or odd-nibble marker
              if (!dv_s) begin
                st_d = mrx_pkg::ST_IDLE;
              end
            end
            default: begin
              st_d = mrx_pkg::ST_IDLE;
            end
          endcase
        end
      end

      // ======================================================================
      // port state registers
      always_ff @(posedge core_clk) begin
        if (rst) begin
          clk_d1_q <= 1'b0;
          st_q     <= mrx_pkg::ST_IDLE;
          pcnt_q   <= '0;
          dcnt_q   <= '0;
          prev_q   <= '0;
          strm_q   <= '0;
        end else begin
          clk_d1_q <= clk_s;
          st_q     <= st_d;
          pcnt_q   <= pcnt_d;
          dcnt_q   <= dcnt_d;
          prev_q   <= prev_d;
          strm_q   <= strm_d;
        end
      end

      assign ev[p]      = ev_p;
      assign rx_strm[p] = strm_q;
    end
  endgenerate

  // ==========================================================================
  // register writes, sticky status and interrupt
  always_comb begin
    iclr = '0;
    for (int i = 0; i < NP; i++) begin
      plim_d[i] = plim_q[i];
      flim_d[i] = flim_q[i];
      // only hardware events reach the error status; bus writes never do
      err_d[i]  = err_q[i] | ev[i];
    end
    ien_d = ien_q;
    if (reg_wr) begin
      case (reg_addr)
        mrx_pkg::OFF_PRE_LIMITS0: plim_d[0] = reg_wdata[7:0];
        mrx_pkg::OFF_PRE_LIMITS1: plim_d[1] = reg_wdata[7:0];
        mrx_pkg::OFF_FRM_LIMITS0: flim_d[0] = reg_wdata;
        mrx_pkg::OFF_FRM_LIMITS1: flim_d[1] = reg_wdata;
        mrx_pkg::OFF_IRQ_CLEAR:   iclr      = reg_wdata[IW-1:0];
        mrx_pkg::OFF_IRQ_ENABLE:  ien_d     = reg_wdata[IW-1:0];
        default: begin
        end
      endcase
    end
    // a new event beats a clear in the same cycle
    ist_d = (ist_q & ~iclr) | ev;
    irq_d = |(ist_d & ien_d);
  end

  // ==========================================================================
  // register reads
  always_comb begin
    // read data are zero outside the cycle after a read strobe
    rdata_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        mrx_pkg::OFF_PRE_LIMITS0: rdata_d = {24'h000000, plim_q[0]};
        mrx_pkg::OFF_PRE_LIMITS1: rdata_d = {24'h000000, plim_q[1]};
        mrx_pkg::OFF_FRM_LIMITS0: rdata_d = flim_q[0];
        mrx_pkg::OFF_FRM_LIMITS1: rdata_d = flim_q[1];
        mrx_pkg::OFF_ERR_STATUS0: rdata_d = {28'h0000000, err_q[0]};
        mrx_pkg::OFF_ERR_STATUS1: rdata_d = {28'h0000000, err_q[1]};
        mrx_pkg::OFF_IRQ_STATUS:  rdata_d = {24'h000000, ist_q};
        mrx_pkg::OFF_IRQ_ENABLE:  rdata_d = {24'h000000, ien_q};
        default:                  rdata_d = '0;
      endcase
    end
  end

  // ==========================================================================
  // register file flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < NP; i++) begin
        plim_q[i] <= mrx_pkg::PRE_LIMITS_RST;
        flim_q[i] <= mrx_pkg::FRM_LIMITS_RST;
        err_q[i]  <= '0;
      end
      ist_q   <= '0;
      ien_q   <= mrx_pkg::IRQ_ENABLE_RST;
      irq_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        plim_q[i] <= plim_d[i];
        flim_q[i] <= flim_d[i];
        err_q[i]  <= err_d[i];
      end
      ist_q   <= ist_d;
      ien_q   <= ien_d;
      irq_q   <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // outputs straight from their flops
  assign reg_rdata = rdata_q;
  assign irq       = irq_q;

endmodule // mrx_top

// file: testbench/mrx_phy_model.sv
// phy model: drives one mii receive port with framed nibbles
`timescale 1ns/1ns
module mrx_phy_model (
  output logic       rx_clk,
  output logic       rx_dv,
  output logic [3:0] rxd
);
  initial begin
    rx_clk = 1'b0;
    rx_dv  = 1'b0;
    rxd    = 4'h0;
  end
  // one link period; data launched long before the sampling fall
  task automatic nib(input logic dv, input logic [3:0] v);
    rx_dv = dv;
    rxd   = v;
    #40 rx_clk = 1'b1;
    #80 rx_clk = 1'b0;
    #40;
  endtask
  // npre-2 preamble nibbles, the two delimiter nibbles if sfd is set, then ndat data nibbles
  task automatic frame(input int npre, input logic [3:0] pv, input bit sfd, input int ndat);
    // step off the core clock edge so pins never change as they are sampled
    #5;
    for (int i = 0; i < npre - 2; i++) nib(1'b1, pv);
    if (sfd) begin
      nib(1'b1, 4'h5);
      nib(1'b1, 4'hD);
    end
    for (int i = 0; i < ndat; i++) nib(1'b1, 4'(i));
    // released data line shows the inverse of the last nibble, then that last nibble again
    nib(1'b0, ~rxd);
    nib(1'b0, ~rxd);
  endtask
endmodule // mrx_phy_model

// file: testbench/mrx_chk_assertions.sv
// checker: concurrent properties on the ports of the receive checker
`timescale 1ns/1ns
module mrx_chk (
  input wire logic                               core_clk,
  input wire logic                               rst,
  input wire logic [mrx_pkg::ADDR_W-1:0]         reg_addr,
  input wire logic [mrx_pkg::DATA_W-1:0]         reg_wdata,
  input wire logic                               reg_wr,
  input wire logic                               reg_rd,
  input wire logic [mrx_pkg::DATA_W-1:0]         reg_rdata,
  input wire logic [mrx_pkg::NPORT-1:0]          mii_rx_clk,
  input wire logic [mrx_pkg::NPORT-1:0]          mii_rx_dv,
  input wire logic [mrx_pkg::NPORT-1:0][3:0]     mii_rxd,
  input mrx_pkg::mrx_strm_t [mrx_pkg::NPORT-1:0] rx_strm,
  input wire logic                               irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // sequences
  sequence trunc0_s;
    rx_strm[0].trunc && rx_strm[0].vld;
  endsequence
  sequence no_eof0_s;
    !rx_strm[0].eof [*8];
  endsequence
  // ==========================================================================
  // properties
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its slot");
  err_rsvd_a: assert property ($past(reg_rd)
    && ($past(reg_addr) inside {8'h50, 8'h54}) |-> reg_rdata[31:4] == '0)
    else $error("status upper bits set");
  pre_rsvd_a: assert property ($past(reg_rd)
    && ($past(reg_addr) inside {8'h48, 8'h4C}) |-> reg_rdata[31:8] == '0)
    else $error("limit upper bits set");
  trunc_vld_a: assert property (rx_strm[0].trunc |-> trunc0_s)
    else $error("cut without forwarded nibble");
  trunc_eof_a: assert property (trunc0_s |=> no_eof0_s)
    else $error("end mark after cut");
  odd_eof_a: assert property (rx_strm[1].odd |-> rx_strm[1].eof)
    else $error("odd flag without end mark");
  vld_pulse_a: assert property (rx_strm[0].vld |=> !rx_strm[0].vld)
    else $error("nibble pulse too long");
  nib_pass_a: assert property (rx_strm[0].vld |->
    rx_strm[0].nib == $past(mii_rxd[0], 4) && $past(mii_rx_dv[0], 4))
    else $error("forwarded nibble differs");
  eof_dv_a: assert property (rx_strm[1].eof |-> !$past(mii_rx_dv[1], 4))
    else $error("end mark while valid high");
  irq_fall_a: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("interrupt fell without write");
endmodule // mrx_chk

bind mrx_top mrx_chk mrx_chk_i (
  .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .mii_rx_clk, .mii_rx_dv, .mii_rxd, .rx_strm, .irq
);

// file: testbench/tb_top.sv
// testbench: registers, frame checks and interrupt of the receive checker
`timescale 1ns/1ns
module tb_top;
  logic                                    core_clk = 1'b0;
  logic                                    rst = 1'b1;
  logic [mrx_pkg::ADDR_W-1:0]              reg_addr = '0;
  logic [mrx_pkg::DATA_W-1:0]              reg_wdata = '0;
  logic                                    reg_wr = 1'b0;
  logic                                    reg_rd = 1'b0;
  logic [mrx_pkg::DATA_W-1:0]              reg_rdata;
  wire  [mrx_pkg::NPORT-1:0]               mii_rx_clk;
  wire  [mrx_pkg::NPORT-1:0]               mii_rx_dv;
  wire  [mrx_pkg::NPORT-1:0][3:0]          mii_rxd;
  mrx_pkg::mrx_strm_t [mrx_pkg::NPORT-1:0] rx_strm;
  logic                                    irq;
  logic                                    odd_seen = 1'b0;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int ntr = 0;
  int nv [2] = '{0, 0};
  int ne [2] = '{0, 0};

  always #10 core_clk = ~core_clk;

  mrx_top mrx_top_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mii_rx_clk(mii_rx_clk), .mii_rx_dv(mii_rx_dv), .mii_rxd(mii_rxd),
    .rx_strm(rx_strm), .irq(irq));
  mrx_phy_model phy0_i (.rx_clk(mii_rx_clk[0]), .rx_dv(mii_rx_dv[0]), .rxd(mii_rxd[0]));
  mrx_phy_model phy1_i (.rx_clk(mii_rx_clk[1]), .rx_dv(mii_rx_dv[1]), .rxd(mii_rxd[1]));

  // ==========================================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(posedge core_clk);
    chk(reg_rdata, exp);
  endtask
  // lets the end mark and status update land after a frame
  task automatic gap;
    repeat (12) @(posedge core_clk);
  endtask
  task automatic results;
    $display("mismatches %0d comparisons %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // monitor and watchdog
  always @(posedge core_clk) begin
    cycles++;
    for (int p = 0; p < 2; p++) begin
      if (rx_strm[p].vld === 1'b1) nv[p]++;
      if (rx_strm[p].eof === 1'b1) ne[p]++;
    end
    if (rx_strm[0].trunc === 1'b1) ntr++;
    if (rx_strm[1].eof === 1'b1) odd_seen = rx_strm[1].odd;
    if (cycles == 40000) begin
      num_errors++;
      results;
    end
  end

  // ==========================================================================
  // sequence of tests
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h40, 32'h05F1003F);
    rd(8'h44, 32'h05F1003F);
    rd(8'h48, 32'h000000E1);
    rd(8'h4C, 32'h000000E1);
    rd(8'h50, 32'h0);
    rd(8'h54, 32'h0);
    rd(8'h58, 32'h0);
    rd(8'h60, 32'h0);
    rd(8'h5C, 32'h0);
    wr(8'h50, 32'hF);
    wr(8'h70, 32'hF);
    rd(8'h50, 32'h0);
    rd(8'h70, 32'h0);
    // preamble nibbles of value 3 still count
    phy0_i.frame(6, 4'h3, 1'b1, 128);
    gap;
    chk(nv[0], 134);
    chk(ne[0], 1);
    rd(8'h50, 32'h0);
    wr(8'h48, 32'hE6);
    phy0_i.frame(6, 4'h3, 1'b1, 128);
    gap;
    rd(8'h50, 32'h1);
    rd(8'h54, 32'h0);
    rd(8'h58, 32'h1);
    chk(irq, 1'b0);
    wr(8'h60, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b1);
    wr(8'h5C, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0);
    rd(8'h58, 32'h0);
    rd(8'h50, 32'h1);
    // port 1: delimiter by nibble 4, four bytes allowed
    wr(8'h4C, 32'h21);
    wr(8'h44, 32'h00030000);
    phy1_i.frame(4, 4'h5, 1'b1, 8);
    gap;
    rd(8'h54, 32'h0);
    phy1_i.frame(4, 4'h5, 1'b1, 10);
    gap;
    rd(8'h54, 32'h8);
    wr(8'h44, 32'h00030010);
    phy1_i.frame(6, 4'h5, 1'b1, 21);
    gap;
    rd(8'h54, 32'hE);
    chk(odd_seen, 1'b1);
    // no delimiter: cut at sixteen nibbles
    nv[0] = 0;
    ne[0] = 0;
    phy0_i.frame(20, 4'h5, 1'b0, 0);
    gap;
    chk(nv[0], 16);
    chk(ntr, 1);
    chk(ne[0], 0);
    rd(8'h50, 32'h3);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h50, 32'h0);
    rd(8'h54, 32'h0);
    rd(8'h48, 32'h000000E1);
    rd(8'h4C, 32'h000000E1);
    rd(8'h58, 32'h0);
    // both preamble limits off: a long and an empty preamble both pass
    wr(8'h4C, 32'h00);
    phy1_i.frame(14, 4'hA, 1'b1, 128);
    gap;
    rd(8'h54, 32'h0);
    phy1_i.frame(2, 4'h5, 1'b1, 128);
    gap;
    rd(8'h54, 32'h0);
    results;
  end
endmodule // tb_top
